// ==== hw/csw_status.sv ====
// card status word: sticky flags, state code and serial response shifter
`timescale 1ns/1ns
`include "csw_params.svh"
// Operation
// - bit 31 set when a command argument is argument_limit_fault
// - bit 30 set on an address misaligned to block length
// - bit 29 set on bad block length or byte count mismatch
// - bit 28 set when erase commands arrive out of order
// - bit 27 set on invalid erase selection found during execution
// - bit 26 set when writing a protected block is attempted
// - bit 25 follows the lock state, not cleared by reading
// - bit 24 set on lock/unlock failure or access to locked card
// - bit 23 set when previous command checksum failed; next valid command after it is reported clears
// - bit 22 set on command illegal in state; next valid command after it is reported clears
// - bit 21 set when error correction failed on data
// - bit 20 on controller error, bit 19 on general error
// - bit 18 set on stream read underrun
// - bit 17 set on stream write overrun
// - bit 16 set on identity or specific register rewrite faults
// - bit 15 set when erase skipped protected blocks
// - bit 14 follows whether error correction was disabled
// - bit 13 set when a pending erase sequence was discarded
// - bits 12 to 9 carry state code 0..8; 9..15 reserved
// - bit 8 mirrors the bus buffer-empty indication
// - bit 5 set when an application-specific command is expected or used
// - the 32-bit word is sent in every short response
// - previous-command flags clear on the next valid command after they are reported
// - an illegal command leaves the state code unchanged
module csw_status (
  input wire logic clock,
  input wire logic resetn,
  input wire logic hostClk,
  input wire logic cmdValid,
  input wire logic cmdCheckBad,
  input wire logic cmdIllegal,
  input wire logic argumentLimitFault,
  input wire logic addrAlignFault,
  input wire logic lengthMismatchFault,
  input wire logic eraseOrderFault,
  input wire logic eraseSelectionFault,
  input wire logic protectedWriteFault,
  input wire logic lockFailFault,
  input wire logic eccFailFault,
  input wire logic controllerFault,
  input wire logic generalFault,
  input wire logic underrunFault,
  input wire logic overrunFault,
  input wire logic idSpecRewriteFault,
  input wire logic eraseSkipped,
  input wire logic eraseDiscarded,
  input wire logic appSpecificNext,
  input wire logic lockedIn,
  input wire logic eccDisabledIn,
  input wire logic bufferEmptyIn,
  input wire logic [3:0] stateIn,
  input wire logic stateLoad,
  input wire logic rspLoad,
  output logic [31:0] statusWord,
  output logic statusBit,
  output logic rspBusy,
  output logic rspSent
);
  // reset release pipeline; assertion is immediate, release is clean
  logic [1:0] rstPipe_q;
  logic [1:0] rstPipe_d;
  logic rstn;

  // a one shifts in, so release waits two edges after the pin rises
  always_comb begin
    rstPipe_d = {rstPipe_q[0], 1'b1};
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rstPipe_q <= 2'h0;
    end else begin
      rstPipe_q <= rstPipe_d;
    end
  end
  // only the second stage is read, so a half-released pipe never reaches the flops
  assign rstn = rstPipe_q[1];

  // host clock arrives on a pin; only its synchronised rising edge is used
  logic hostRise;

  csw_sync u_host_sync (
    .clock(clock),
    .rstn(rstn),
    .asyncIn(hostClk),
    .levelOut(),
    .risePulse(hostRise)
  );

  // sets a single bit at a named position
  function automatic logic [31:0] bitAt(input logic en, input int pos);
    logic [31:0] v;
    v = 32'h00000000;
    v[pos] = en;
    return v;
  endfunction

  // collected set requests, one per sticky flag
  logic [31:0] setReq;

  always_comb begin
    setReq = 32'h00000000;
    setReq = setReq | bitAt(argumentLimitFault, `CSW_BIT_ARG_LIMIT);
    setReq = setReq | bitAt(addrAlignFault, `CSW_BIT_ADDR_ALIGN);
    setReq = setReq | bitAt(lengthMismatchFault, `CSW_BIT_LEN_MISMATCH);
    setReq = setReq | bitAt(eraseOrderFault, `CSW_BIT_ERASE_ORDER);
    setReq = setReq | bitAt(eraseSelectionFault, `CSW_BIT_ERASE_SEL);
    setReq = setReq | bitAt(protectedWriteFault, `CSW_BIT_PROT_WRITE);
    setReq = setReq | bitAt(lockFailFault, `CSW_BIT_LOCK_FAIL);
    setReq = setReq | bitAt(cmdCheckBad, `CSW_BIT_CMD_CHECK);
    setReq = setReq | bitAt(cmdIllegal, `CSW_BIT_ILLEGAL);
    setReq = setReq | bitAt(eccFailFault, `CSW_BIT_ECC_FAIL);
    setReq = setReq | bitAt(controllerFault, `CSW_BIT_CONTROLLER);
    setReq = setReq | bitAt(generalFault, `CSW_BIT_GENERAL);
    setReq = setReq | bitAt(underrunFault, `CSW_BIT_UNDERRUN);
    setReq = setReq | bitAt(overrunFault, `CSW_BIT_OVERRUN);
    setReq = setReq | bitAt(idSpecRewriteFault, `CSW_BIT_ID_REWRITE);
    setReq = setReq | bitAt(eraseSkipped, `CSW_BIT_ERASE_SKIP);
    setReq = setReq | bitAt(eraseDiscarded, `CSW_BIT_ERASE_RESET);
    setReq = setReq | bitAt(appSpecificNext, `CSW_BIT_APP_NEXT);
  end

  // sticky flags, level copies and the state code
  logic [31:0] flags_q;
  logic [31:0] flags_d;
  logic [31:0] sentPrev_q;
  logic [31:0] sentPrev_d;
  logic locked_q;
  logic locked_d;
  logic eccOff_q;
  logic eccOff_d;
  logic bufEmpty_q;
  logic bufEmpty_d;
  csw_pkg::csw_card_state_t state_q;
  csw_pkg::csw_card_state_t state_d;
  logic [31:0] word_q;
  logic [31:0] word_d;
  logic [31:0] snap_q;
  logic [31:0] snap_d;
  logic sent_q;
  logic sent_d;

  // clears act only on flags already reported; a set in the same cycle wins
  always_comb begin
    logic [31:0] clr;
    clr = 32'h00000000;
    sentPrev_d = sentPrev_q;
    if (cmdValid) begin
      clr = clr | (sentPrev_q & `CSW_NEXT_CMD_MASK);
      sentPrev_d = 32'h00000000;
    end
    // clear after send; marks made now survive a command in the same cycle
    // limitation: a flag raised again while its report is shifting out is cleared with it
    if (sent_q) begin
      clr = clr | (snap_q & `CSW_READ_CLR_MASK);
      sentPrev_d = sentPrev_d | (snap_q & `CSW_NEXT_CMD_MASK);
    end
    flags_d = ((flags_q & ~clr) | setReq) & (`CSW_READ_CLR_MASK | `CSW_NEXT_CMD_MASK);
    locked_d = lockedIn;
    eccOff_d = eccDisabledIn;
    bufEmpty_d = bufferEmptyIn;
    state_d = state_q;
    // illegal keeps state; reserved codes are refused
    if (stateLoad && !cmdIllegal && stateIn <= `CSW_STATE_LAST) begin
      state_d = csw_pkg::csw_card_state_t'(stateIn);
    end
  end

  // assembled word; unused low bits stay zero
  always_comb begin
    word_d = flags_q;
    word_d = word_d | bitAt(locked_q, `CSW_BIT_LOCKED);
    word_d = word_d | bitAt(eccOff_q, `CSW_BIT_ECC_OFF);
    word_d = word_d | bitAt(bufEmpty_q, `CSW_BIT_BUF_EMPTY);
    word_d[`CSW_STATE_LSB +: 4] = state_q;
    word_d[7:6] = 2'h0;
    word_d[4:0] = 5'h00;
  end

  // flag, mirror and state registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      flags_q <= `CSW_WORD_RESET;
      sentPrev_q <= 32'h00000000;
      locked_q <= 1'b0;
      eccOff_q <= 1'b0;
      bufEmpty_q <= 1'b0;
      state_q <= csw_pkg::CSW_IDLE;
    end else begin
      flags_q <= flags_d;
      sentPrev_q <= sentPrev_d;
      locked_q <= locked_d;
      eccOff_q <= eccOff_d;
      bufEmpty_q <= bufEmpty_d;
      state_q <= state_d;
    end
  end

  // word register; costs one edge of lag but the output never glitches
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      word_q <= `CSW_WORD_RESET;
    end else begin
      word_q <= word_d;
    end
  end

  // response shifter: word leaves msb first, one bit per host rising edge
  csw_pkg::csw_shift_state_t shState_q;
  csw_pkg::csw_shift_state_t shState_d;
  logic [31:0] shift_q;
  logic [31:0] shift_d;
  logic [`CSW_CNT_W-1:0] cnt_q;
  logic [`CSW_CNT_W-1:0] cnt_d;
  logic bit_q;
  logic bit_d;

  // a load while busy is ignored so a word is never torn mid-frame
  always_comb begin
    shState_d = shState_q;
    shift_d = shift_q;
    cnt_d = cnt_q;
    bit_d = bit_q;
    snap_d = snap_q;
    sent_d = 1'b0;
    unique case (shState_q)
      csw_pkg::CSW_SH_IDLE: begin
        if (rspLoad) begin
          snap_d = word_q;
          shift_d = word_q;
          cnt_d = `CSW_CNT_W'(`CSW_WORD_W);
          shState_d = csw_pkg::CSW_SH_SHIFT;
        end
      end
      csw_pkg::CSW_SH_SHIFT: begin
        if (hostRise) begin
          bit_d = shift_q[31];
          shift_d = {shift_q[30:0], 1'b0};
          cnt_d = cnt_q - `CSW_CNT_W'(1);
          if (cnt_q == `CSW_CNT_W'(1)) begin
            sent_d = 1'b1;
            shState_d = csw_pkg::CSW_SH_IDLE;
          end
        end
      end
    endcase
  end

  // shifter registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      shState_q <= csw_pkg::CSW_SH_IDLE;
      shift_q <= 32'h00000000;
      cnt_q <= `CSW_CNT_W'(0);
      bit_q <= 1'b0;
      snap_q <= 32'h00000000;
      sent_q <= 1'b0;
    end else begin
      shState_q <= shState_d;
      shift_q <= shift_d;
      cnt_q <= cnt_d;
      bit_q <= bit_d;
      snap_q <= snap_d;
      sent_q <= sent_d;
    end
  end

  // every output is a straight flop copy
  assign statusWord = word_q;
  assign statusBit = bit_q;
  assign rspBusy = shState_q;
  assign rspSent = sent_q;
endmodule

// ==== hw/csw_sync.sv ====
// two-flop synchroniser with rising-edge pulse for the host clock pin
`timescale 1ns/1ns
module csw_sync (
  input wire logic clock,
  input wire logic rstn,
  input wire logic asyncIn,
  output logic levelOut,
  output logic risePulse
);
  logic meta_q;
  logic meta_d;
  logic stable_q;
  logic stable_d;
  logic last_q;
  logic last_d;
  logic rise_q;
  logic rise_d;

  // the first stage feeds only the second; the edge uses stages two and three
  always_comb begin
    meta_d = asyncIn;
    stable_d = meta_q;
    last_d = stable_q;
    rise_d = stable_q & ~last_q;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta_q <= 1'b0;
      stable_q <= 1'b0;
      last_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      stable_q <= stable_d;
      last_q <= last_d;
      rise_q <= rise_d;
    end
  end

  assign levelOut = last_q;
  assign risePulse = rise_q;
endmodule

// ==== inc/csw_params.svh ====
// constants for the card status word block: bit positions, masks, codes
`ifndef CSW_PARAMS_SVH
`define CSW_PARAMS_SVH
`define CSW_WORD_W 32
`define CSW_CNT_W 6
`define CSW_BIT_ARG_LIMIT 31
`define CSW_BIT_ADDR_ALIGN 30
`define CSW_BIT_LEN_MISMATCH 29
`define CSW_BIT_ERASE_ORDER 28
`define CSW_BIT_ERASE_SEL 27
`define CSW_BIT_PROT_WRITE 26
`define CSW_BIT_LOCKED 25
`define CSW_BIT_LOCK_FAIL 24
`define CSW_BIT_CMD_CHECK 23
`define CSW_BIT_ILLEGAL 22
`define CSW_BIT_ECC_FAIL 21
`define CSW_BIT_CONTROLLER 20
`define CSW_BIT_GENERAL 19
`define CSW_BIT_UNDERRUN 18
`define CSW_BIT_OVERRUN 17
`define CSW_BIT_ID_REWRITE 16
`define CSW_BIT_ERASE_SKIP 15
`define CSW_BIT_ECC_OFF 14
`define CSW_BIT_ERASE_RESET 13
`define CSW_STATE_LSB 9
`define CSW_BIT_BUF_EMPTY 8
`define CSW_BIT_APP_NEXT 5
// flags cleared once reported in a response
`define CSW_READ_CLR_MASK 32'hfd3fa020
// flags cleared by the next valid command after being reported
`define CSW_NEXT_CMD_MASK 32'h00c00000
`define CSW_WORD_RESET 32'h00000000
`define CSW_STATE_RESET 4'h0
`define CSW_STATE_LAST 4'h8
`endif

// ==== inc/csw_pkg.sv ====
// types for the card status word block
package csw_pkg;
  typedef enum logic [3:0] {
    CSW_IDLE = 4'h0,
    CSW_READY = 4'h1,
    CSW_IDENT = 4'h2,
    CSW_STANDBY = 4'h3,
    CSW_TRANSFER = 4'h4,
    CSW_DATA = 4'h5,
    CSW_RECEIVE = 4'h6,
    CSW_PROGRAM = 4'h7,
    CSW_DISCONNECT = 4'h8
  } csw_card_state_t;
  typedef enum logic [0:0] {
    CSW_SH_IDLE = 1'b0,
    CSW_SH_SHIFT = 1'b1
  } csw_shift_state_t;
endpackage

// ==== verif/csw_host.sv ====
// host side model that clocks one status word in per response
`timescale 1ns/1ns
module csw_host (
  input wire logic rspBusy,
  input wire logic statusBit,
  input wire logic [8:0] lag,
  output logic hostClk,
  output logic [31:0] word,
  output logic done
);
  // host clock idles low; sample late in the low phase so the bit has settled
  initial begin
    hostClk = 1'b0;
    word = '0;
    done = 1'b0;
    forever begin
      @(posedge rspBusy);
      // start off the system clock edges so the pin never races its sampler
      #(lag + 9'h005);
      repeat (32) begin
        hostClk = 1'b1;
        #80 hostClk = 1'b0;
        #79 word = {word[30:0], statusBit};
        #1;
      end
      done = 1'b1;
      #20 done = 1'b0;
    end
  end
endmodule

// ==== verif/csw_status_properties.sv ====
// port checks for the card status word block
`timescale 1ns/1ns
module csw_chk (
  input wire logic clock,
  input wire logic resetn,
  input wire logic cmdCheckBad,
  input wire logic cmdIllegal,
  input wire logic argumentLimitFault,
  input wire logic lockedIn,
  input wire logic bufferEmptyIn,
  input wire logic [3:0] stateIn,
  input wire logic stateLoad,
  input wire logic rspLoad,
  input wire logic [31:0] statusWord,
  input wire logic rspBusy,
  input wire logic rspSent
);
  // the block leaves reset two edges after the pin and its word lags two more
  logic [2:0] upCnt_q;
  logic live;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      upCnt_q <= 3'h0;
    end else if (upCnt_q != 3'h6) begin
      upCnt_q <= upCnt_q + 3'h1;
    end
  end
  assign live = (upCnt_q == 3'h6);
  // one domain; checks wait until the internal release and the word lag have passed
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn || !live);
  sequence s_take;
    rspLoad && !rspBusy;
  endsequence
  sequence s_refused;
    stateLoad && (cmdIllegal || stateIn > 4'h8) ##1 !stateLoad;
  endsequence
  property p_arg;
    argumentLimitFault |-> ##2 statusWord[31];
  endproperty
  a_arg: assert property (p_arg) else $error("bit31 not set");
  property p_crc;
    cmdCheckBad |-> ##2 statusWord[23];
  endproperty
  a_crc: assert property (p_crc) else $error("bit23 not set");
  property p_ill;
    cmdIllegal |-> ##2 statusWord[22];
  endproperty
  a_ill: assert property (p_ill) else $error("bit22 not set");
  property p_lock;
    statusWord[25] == $past(lockedIn, 2);
  endproperty
  a_lock: assert property (p_lock) else $error("bit25 wrong");
  property p_empty;
    statusWord[8] == $past(bufferEmptyIn, 2);
  endproperty
  a_empty: assert property (p_empty) else $error("bit8 wrong");
  property p_state;
    stateLoad && !cmdIllegal && stateIn < 4'h9 |-> ##2 statusWord[12:9] == $past(stateIn, 2);
  endproperty
  a_state: assert property (p_state) else $error("state code wrong");
  property p_keep;
    s_refused |-> ##1 $stable(statusWord[12:9]);
  endproperty
  a_keep: assert property (p_keep) else $error("state changed");
  property p_zero;
    statusWord[7:6] == 2'h0 && statusWord[4:0] == 5'h0;
  endproperty
  a_zero: assert property (p_zero) else $error("reserved bits set");
  property p_busy;
    s_take |=> rspBusy [*8];
  endproperty
  a_busy: assert property (p_busy) else $error("busy dropped");
  property p_done;
    $fell(rspBusy) |-> rspSent ##1 !rspSent;
  endproperty
  a_done: assert property (p_done) else $error("sent pulse wrong");
endmodule
bind csw_status csw_chk chk (.clock(clock), .resetn(resetn), .cmdCheckBad(cmdCheckBad), .cmdIllegal(cmdIllegal),
  .argumentLimitFault(argumentLimitFault), .lockedIn(lockedIn), .bufferEmptyIn(bufferEmptyIn), .stateIn(stateIn),
  .stateLoad(stateLoad), .rspLoad(rspLoad), .statusWord(statusWord), .rspBusy(rspBusy), .rspSent(rspSent));

// ==== verif/test_csw_status.sv ====
// bench for the card status word block
`timescale 1ns/1ns
`include "csw_params.svh"
module test_csw_status;
  logic clock, resetn, cmdValid, cmdCheckBad, cmdIllegal, stateLoad, rspLoad;
  logic lockedIn, eccDisabledIn, bufferEmptyIn, statusBit, rspBusy, rspSent, hostClk, done;
  logic [15:0] ev;
  logic [8:0] lag;
  logic [3:0] stateIn, expState;
  logic [31:0] statusWord, word, flags, bMark, w;
  logic [31:0] expQ[$];
  int err_count = 0;
  int n_tests = 0;
  int seed, i;
  int bitOf[16] = '{31, 30, 29, 28, 27, 26, 24, 21, 20, 19, 18, 17, 16, 15, 13, 5};
  csw_status uut (.clock(clock), .resetn(resetn), .hostClk(hostClk), .cmdValid(cmdValid), .cmdCheckBad(cmdCheckBad),
    .cmdIllegal(cmdIllegal), .lockedIn(lockedIn), .eccDisabledIn(eccDisabledIn), .bufferEmptyIn(bufferEmptyIn),
    .stateIn(stateIn), .stateLoad(stateLoad), .rspLoad(rspLoad), .statusWord(statusWord), .statusBit(statusBit),
    .rspBusy(rspBusy), .rspSent(rspSent), .argumentLimitFault(ev[0]), .addrAlignFault(ev[1]), .lengthMismatchFault(ev[2]),
    .eraseOrderFault(ev[3]), .eraseSelectionFault(ev[4]), .protectedWriteFault(ev[5]), .lockFailFault(ev[6]),
    .eccFailFault(ev[7]), .controllerFault(ev[8]), .generalFault(ev[9]), .underrunFault(ev[10]),
    .overrunFault(ev[11]), .idSpecRewriteFault(ev[12]), .eraseSkipped(ev[13]), .eraseDiscarded(ev[14]),
    .appSpecificNext(ev[15]));
  csw_host host (.rspBusy(rspBusy), .statusBit(statusBit), .lag(lag), .hostClk(hostClk), .word(word), .done(done));
  // free-running system clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic tick(int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic cmp_word(logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic summarize;
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // one-cycle event pulse; set beats clear, as the block does
  task automatic pulse(logic [15:0] e, logic c, logic il, logic v, logic ld, logic [3:0] s);
    ev <= e;
    cmdCheckBad <= c;
    cmdIllegal <= il;
    cmdValid <= v;
    stateLoad <= ld;
    stateIn <= s;
    tick(1);
    ev <= '0;
    {cmdCheckBad, cmdIllegal, cmdValid, stateLoad} <= '0;
    tick(1);
    if (v) flags &= ~bMark;
    if (v) bMark = '0;
    for (int k = 0; k < 16; k++) if (e[k]) flags[bitOf[k]] = 1'b1;
    flags[23] |= c;
    flags[22] |= il;
    if (ld && !il && s < 4'h9) expState = s;
  endtask
  // request a response word; dup retries the load mid-frame, which must be ignored
  task automatic respond(logic [8:0] lg, logic dup);
    int k;
    tick(3);
    w = flags | {6'h0, lockedIn, 10'h0, eccDisabledIn, 1'b0, expState, bufferEmptyIn, 8'h0};
    expQ.push_back(w);
    lag <= lg;
    rspLoad <= 1'b1;
    tick(1);
    rspLoad <= 1'b0;
    if (dup) begin
      tick(9);
      rspLoad <= 1'b1;
      tick(1);
      rspLoad <= 1'b0;
    end
    k = 0;
    while (done !== 1'b1) begin
      @(negedge clock);
      k++;
      if (k > 3000) begin
        err_count++;
        summarize();
      end
    end
    tick(1);
    flags &= ~(w & `CSW_READ_CLR_MASK);
    bMark |= w & `CSW_NEXT_CMD_MASK;
  endtask
  // compare each received word with the oldest note
  always @(posedge done) begin
    if (expQ.size() > 0) cmp_word(expQ.pop_front(), word);
    else begin
      err_count++;
      $display("BAD %0t extra word", $time);
    end
  end
  // main sequence
  initial begin
    seed = 96;
    {resetn, cmdValid, cmdCheckBad, cmdIllegal, stateLoad, rspLoad} = '0;
    {lockedIn, eccDisabledIn, bufferEmptyIn} = '0;
    ev = '0;
    stateIn = '0;
    expState = '0;
    flags = '0;
    bMark = '0;
    lag = '0;
    tick(8);
    resetn <= 1'b1;
    tick(4);
    respond(0, 0);
    $display("test reset word done");
    for (i = 0; i < 16; i++) begin
      pulse(16'h1 << i, 0, 0, 0, 0, 0);
      respond(0, 0);
      respond(9'(40 * (i % 3)), 0);
    end
    $display("test single flags done");
    repeat (6) begin
      lockedIn <= 1'($random(seed));
      eccDisabledIn <= 1'($random(seed));
      bufferEmptyIn <= 1'($random(seed));
      pulse(16'($random(seed)), 0, 0, 0, 1, 4'($unsigned($random(seed)) % 9));
      respond(0, 0);
      respond(20, 0);
    end
    $display("test random mix done");
    pulse(0, 0, 0, 0, 1, 4'h4);
    pulse(0, 1, 1, 0, 1, 4'h6);
    pulse(0, 0, 0, 1, 0, 0);
    respond(0, 0);
    respond(0, 0);
    pulse(0, 0, 1, 1, 0, 0);
    respond(0, 1);
    pulse(0, 0, 0, 0, 1, 4'h9 + 4'($unsigned($random(seed)) % 7));
    respond(0, 0);
    cmp_word(32'(expQ.size()), 32'h0);
    $display("test command clear done");
    summarize();
  end
endmodule
